// file: hw/pssc_pkg.sv
// package for the pipelined sync sram cycle control block
// assumes a single 200 MHz clock and active-low asynchronous reset
package pssc_pkg;
   // =====================================================
   // geometry
   localparam int DATA_W  = 32;
   localparam int LANES   = 4;
   localparam int LANE_W  = 8;
   localparam int ADDR_W  = 16;
   // =====================================================
   // timing
   localparam int CLK_PERIOD_PS     = 5000;
   localparam int SLEEP_ENTRY_CYC   = 2;   // longest delay into sleep, in cycles
   localparam int SLEEP_EXIT_CYC    = 0;   // least delay out of sleep
   localparam int SLEEP_RECOVER_CYC = 2;  // far side idles this long after release
   // =====================================================
   // burst order strap
   localparam logic BURST_LINEAR = 1'b0;
   // =====================================================
   // reset values
   localparam logic [1:0] BURST_RST = 2'h0;
   typedef enum logic [1:0] {PSSC_IDLE, PSSC_READ, PSSC_WRITE} pssc_cycle_t;
   typedef enum logic [1:0] {PSSC_AWAKE, PSSC_ENTER, PSSC_ASLEEP} pssc_sleep_t;
endpackage

// file: hw/pssc_burst_ctr.sv
// two-bit wraparound burst address counter
// assumes load and advance are already qualified by the caller
`timescale 1ns/1ps
module pssc_burst_ctr
   import pssc_pkg::*;
(
   input  wire logic       clock,     // system clock
   input  wire logic       arst_n,    // async reset, active low
   input  wire logic       load,      // capture start address
   input  wire logic [1:0] start,     // low address bits
   input  wire logic       advance,   // step to next burst address
   input  wire logic       linear,    // linear order when high
   output logic      [1:0] low_addr   // current burst address bits
);
   logic [1:0] start_q;
   logic [1:0] step_q;

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         start_q <= BURST_RST;
         step_q  <= BURST_RST;
      end else if (load) begin
         start_q <= start;
         step_q  <= BURST_RST;
      end else if (advance) begin
         step_q <= step_q + 2'h1;
      end
   end

   // interleaved order is xor with the step, linear is add
   assign low_addr = linear ? 2'(start_q + step_q) : (start_q ^ step_q);
endmodule

// file: hw/pssc_top.sv
// cycle control and write qualification of a 32-bit pipelined sync sram
// assumes all pins but output enable and sleep are synchronous to clock
//
// What this block does
// - processor strobe taken while selected always starts a read, write controls ignored
// - writes only in controller-strobe cycle or in any later cycle of an access
// - data outputs disabled from the cycle after a write; in the write cycle they follow the prior read and output enable
// - output enable gates data drivers combinationally, never registered
// - data pins high impedance when output enable inactive or deselected
// - read with output enable low drives all pins with registered data
// - pin drive depends on current cycle and live output enable
// - write when all-bytes write low, or lane enable low with a lane
// - lane writes touch only selected bytes; all-bytes write writes four
// - normal operation stops within two cycles of sleep assertion
// - sleep state reached no later than two cycles after request
// - sleep may be left immediately on release
// - processor strobe ignored while first chip select is high
// - two-bit burst counter, linear or interleaved, steps on advance low
`timescale 1ns/1ps
module pssc_top
   import pssc_pkg::*;
#(
   parameter int AW = ADDR_W
)(
   input  wire logic              clock,                    // 200 MHz clock
   input  wire logic              arst_n,                   // async reset, active low
   input  wire logic [AW-1:0]     addr,                     // address inputs
   input  wire logic              processor_addr_strobe_n,  // processor strobe
   input  wire logic              controller_addr_strobe_n, // controller strobe
   input  wire logic              burst_advance_n,          // burst advance
   input  wire logic              all_bytes_write_n,        // write all bytes
   input  wire logic              lane_write_enable_n,      // lane write enable
   input  wire logic [LANES-1:0]  lane_select_n,            // lanes a..d = bit 0..3
   input  wire logic              chip_select_1_n,          // chip select 1
   input  wire logic              chip_select_2,            // chip select 2
   input  wire logic              chip_select_3_n,          // chip select 3
   input  wire logic              output_enable_n,          // async output enable
   input  wire logic              sleep_request,            // sleep request
   input  wire logic              burst_order_strap,        // low = linear order
   input  wire logic [DATA_W-1:0] data_in,                  // data pin input
   output logic      [DATA_W-1:0] data_out,                 // data pin output
   output logic      [DATA_W-1:0] data_oe,                  // data pin output enable
   output logic                   asleep                    // in low-power state
);
   // =====================================================
   // memory and state
   logic [DATA_W-1:0] mem [2**AW];
   logic [AW-1:0]     addr_q;
   pssc_cycle_t       cycle_q;
   pssc_sleep_t       sleep_q;
   logic [DATA_W-1:0] rdata_q;
   logic              read_out_q;
   logic              strap_q;
   logic              strap_taken_q;
   logic [1:0]        burst_low;
   logic              burst_load;
   logic              burst_step;

   function automatic logic [LANES-1:0] lane_mask(input logic gw_n, input logic bwe_n,
                                                 input logic [LANES-1:0] bw_n);
      if (!gw_n)
         lane_mask = '1;
      else if (!bwe_n)
         lane_mask = ~bw_n;
      else
         lane_mask = '0;
   endfunction

   // =====================================================
   // start decode
   logic selected;
   logic awake;
   logic proc_start;
   logic ctrl_start;
   logic write_qual;
   logic [LANES-1:0] wr_lanes;
   logic [AW-1:0]    cur_addr;

   assign awake      = (sleep_q == PSSC_AWAKE) && !sleep_request;
   assign selected   = !chip_select_1_n && chip_select_2 && !chip_select_3_n;
   assign proc_start = awake && !processor_addr_strobe_n && !chip_select_1_n;
   assign ctrl_start = awake && !proc_start && !controller_addr_strobe_n;
   assign wr_lanes   = lane_mask(all_bytes_write_n, lane_write_enable_n, lane_select_n);
   assign write_qual = |wr_lanes;
   assign burst_load = (proc_start || ctrl_start) && selected;
   assign burst_step = awake && !burst_load && !burst_advance_n && (cycle_q != PSSC_IDLE);
   assign cur_addr   = {addr_q[AW-1:2], burst_low};

   pssc_burst_ctr u_burst (
      .clock    (clock),
      .arst_n   (arst_n),
      .load     (burst_load),
      .start    (addr[1:0]),
      .advance  (burst_step),
      .linear   (strap_q == BURST_LINEAR),
      .low_addr (burst_low)
   );

   // =====================================================
   // strap capture after reset release
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         strap_q       <= 1'b1;
         strap_taken_q <= 1'b0;
      end else if (!strap_taken_q) begin
         strap_q       <= burst_order_strap;
         strap_taken_q <= 1'b1;
      end
   end

   // =====================================================
   // address register
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n)
         addr_q <= '0;
      else if (burst_load)
         addr_q <= addr;
   end

   // =====================================================
   // cycle state
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         cycle_q <= PSSC_IDLE;
      end else if (!awake) begin
         cycle_q <= PSSC_IDLE;
      end else if (proc_start || ctrl_start) begin
         if (!selected)
            cycle_q <= PSSC_IDLE;
         else if (proc_start)
            cycle_q <= PSSC_READ;
         else
            cycle_q <= write_qual ? PSSC_WRITE : PSSC_READ;
      end else if (cycle_q != PSSC_IDLE) begin
         // continuation cycles follow the live write qualifier
         cycle_q <= write_qual ? PSSC_WRITE : PSSC_READ;
      end
   end

   // =====================================================
   // array write: in a controller-strobe start or any later cycle
   logic wr_now;
   logic [AW-1:0] wr_addr;
   assign wr_now  = awake && write_qual && !proc_start &&
                    (ctrl_start ? selected : (cycle_q != PSSC_IDLE));
   // a later-cycle write lands at the burst address of this cycle; an advance moves the next one
   assign wr_addr = ctrl_start ? addr : cur_addr;

   always_ff @(posedge clock) begin
      if (wr_now) begin
         for (int i = 0; i < LANES; i++) begin
            if (wr_lanes[i])
               mem[wr_addr][i*LANE_W +: LANE_W] <= data_in[i*LANE_W +: LANE_W];
         end
      end
   end

   // =====================================================
   // pipelined read register
   logic [AW-1:0] rd_addr;
   logic          rd_now;
   assign rd_addr = burst_load ? addr : cur_addr;
   assign rd_now  = awake && selected && (proc_start || (ctrl_start && !write_qual));

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         rdata_q    <= '0;
         read_out_q <= 1'b0;
      end else begin
         if (rd_now || (cycle_q == PSSC_READ && !burst_load && awake))
            rdata_q <= mem[rd_addr];
         read_out_q <= awake && (rd_now || (cycle_q == PSSC_READ && !burst_load && !write_qual));
      end
   end

   // =====================================================
   // sleep sequencing
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n)
         sleep_q <= PSSC_AWAKE;
      else if (!sleep_request)
         sleep_q <= PSSC_AWAKE;
      else begin
         case (sleep_q)
            PSSC_AWAKE:  sleep_q <= PSSC_ENTER;
            PSSC_ENTER:  sleep_q <= PSSC_ASLEEP;
            PSSC_ASLEEP: sleep_q <= PSSC_ASLEEP;
            default:     sleep_q <= PSSC_AWAKE;
         endcase
      end
   end
   assign asleep = (sleep_q == PSSC_ASLEEP) && sleep_request;

   // =====================================================
   // data pin drive: registered data, live output enable
   logic drive;
   assign drive    = read_out_q && (cycle_q == PSSC_READ) && !output_enable_n && !asleep;
   assign data_out = rdata_q;
   assign data_oe  = {DATA_W{drive}};
endmodule

// file: dv/pssc_top_properties.sv
// port checker for pssc_top
// assumes it is bound onto pssc_top; one clock domain
`timescale 1ns/1ps
module pssc_top_chk
   import pssc_pkg::*;
(
   input wire logic              clock, // clock
   input wire logic              arst_n, // reset
   input wire logic              processor_addr_strobe_n, // strobe
   input wire logic              controller_addr_strobe_n, // strobe
   input wire logic              all_bytes_write_n, // write
   input wire logic              lane_write_enable_n, // write
   input wire logic [LANES-1:0]  lane_select_n, // lanes
   input wire logic              chip_select_1_n, // select
   input wire logic              chip_select_2, // select
   input wire logic              chip_select_3_n, // select
   input wire logic              output_enable_n, // oe
   input wire logic              sleep_request, // sleep
   input wire logic [DATA_W-1:0] data_oe, // drive
   input wire logic              asleep // low power
);
   // ======================================
   // helpers
   logic wq;
   logic sel;
   logic quiet;
   assign wq = !all_bytes_write_n || (!lane_write_enable_n && lane_select_n != 4'hF);
   assign sel = !chip_select_1_n && chip_select_2 && !chip_select_3_n && !sleep_request;
   assign quiet = processor_addr_strobe_n && controller_addr_strobe_n && !sleep_request;
   default clocking @(posedge clock); endclocking
   default disable iff (!arst_n);
   // ======================================
   // assertions
   AST_OE_OFF: assert property (output_enable_n |-> data_oe == '0)
      else $error("pins driven with oe high");
   AST_READ: assert property ((sel && !processor_addr_strobe_n) ##1 (quiet && !wq && !output_enable_n)
      |=> (output_enable_n || data_oe == '1)) else $error("read data not driven");
   AST_PROC_WR: assert property ((sel && !processor_addr_strobe_n) ##1 (quiet && wq) |=> data_oe == '0)
      else $error("pins driven in write after strobe");
   AST_CTRL_WR: assert property (sel && processor_addr_strobe_n && !controller_addr_strobe_n && wq
      |=> data_oe == '0) else $error("pins driven in write");
   AST_CS1: assert property ((data_oe[0] && !processor_addr_strobe_n && chip_select_1_n &&
      controller_addr_strobe_n && !wq && !sleep_request) |=> (output_enable_n || data_oe[0]))
      else $error("strobe taken with select 1 high");
   AST_SLEEP_IN: assert property (sleep_request [*2] |=> (asleep || !sleep_request))
      else $error("sleep not reached");
   AST_SLEEP_OUT: assert property (!sleep_request |-> !asleep)
      else $error("sleep held after release");
   AST_SLEEP_QUIET: assert property (asleep |-> data_oe == '0)
      else $error("pins driven while asleep");
endmodule
bind pssc_top pssc_top_chk u_chk (.*);

// file: dv/pssc_ctl_bus.sv
// far-side data bus: resolves the shared data pins
// assumes the bench drives write data only with output enable high
`timescale 1ns/1ps
module pssc_ctl_bus
   import pssc_pkg::*;
(
   input  wire logic [DATA_W-1:0] ctl_data, // write data
   input  wire logic              ctl_drive, // controller drives
   input  wire logic [DATA_W-1:0] data_out, // device data
   input  wire logic [DATA_W-1:0] data_oe, // device drives
   output logic      [DATA_W-1:0] data_in // pin level
);
   // nobody driving: pins show the inverse of their last level
   always @(ctl_drive or ctl_data or data_out or data_oe) begin
      if (ctl_drive)
         data_in = ctl_data;
      else if (data_oe[0])
         data_in = data_out;
      else
         data_in = ~data_in;
   end
endmodule

// file: dv/tb.sv
// self-checking bench for pssc_top with its far-side bus model
// assumes pssc_ctl_bus and the bound checker are compiled before it
`timescale 1ns/1ps
module tb;
   import pssc_pkg::*;
   logic        clock = 1'b0, arst_n = 1'b0, ps_n = 1'b1, cs_n = 1'b1, gw_n = 1'b1, bwe_n = 1'b1;
   logic        ce1_n = 1'b0, ce2 = 1'b1, oe_n = 1'b1, zz = 1'b0, cdrv = 1'b0, aslp;
   logic        adv_n = 1'b1, strap = 1'b0;
   logic [3:0]  ln_n = 4'hF;
   logic [15:0] addr = 16'h0000;
   logic [31:0] cdat = 32'h00000000, dout, doe, din;
   logic [31:0] mem [4];
   int          mismatches = 0, cmp_count = 0, k;
   always #2.5 clock = ~clock;
   pssc_top u_dut (.clock(clock), .arst_n(arst_n), .addr(addr), .processor_addr_strobe_n(ps_n),
      .controller_addr_strobe_n(cs_n), .burst_advance_n(adv_n), .all_bytes_write_n(gw_n),
      .lane_write_enable_n(bwe_n), .lane_select_n(ln_n), .chip_select_1_n(ce1_n), .chip_select_2(ce2),
      .chip_select_3_n(1'b0), .output_enable_n(oe_n), .sleep_request(zz), .burst_order_strap(strap),
      .data_in(din), .data_out(dout), .data_oe(doe), .asleep(aslp));
   pssc_ctl_bus u_bus (.ctl_data(cdat), .ctl_drive(cdrv), .data_out(dout), .data_oe(doe), .data_in(din));
   // ======================================
   // compare and close
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask
   task finish_test();
      $display("compares %0d, mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // ======================================
   // accesses
   task wr(input logic [15:0] a, input logic [31:0] d, input logic g, input logic [3:0] l);
      @(posedge clock);
      oe_n <= 1'b1;
      @(posedge clock);
      cs_n <= 1'b0; addr <= a; gw_n <= g; bwe_n <= 1'b0; ln_n <= l; cdrv <= 1'b1; cdat <= d;
      for (int i = 0; i < 4; i++)
         if (!g || !l[i]) mem[a[1:0]][8*i+:8] = d[8*i+:8];
      @(posedge clock);
      cs_n <= 1'b1; gw_n <= 1'b1; bwe_n <= 1'b1; ln_n <= 4'hF; cdrv <= 1'b0;
   endtask
   task rd(input logic [15:0] a);
      @(posedge clock);
      ps_n <= 1'b0; addr <= a; oe_n <= 1'b0; gw_n <= 1'b0;
      @(posedge clock);
      ps_n <= 1'b1; gw_n <= 1'b1;
      #1 chk(dout, mem[a[1:0]]);
      chk(doe, 32'hFFFFFFFF);
   endtask
   // burst read from a, advance low for four cycles, four beats checked; lin selects the expected order
   task bst(input logic [1:0] a, input logic lin);
      @(posedge clock);
      ps_n <= 1'b0; addr <= {14'h0000, a}; oe_n <= 1'b0;
      @(posedge clock);
      ps_n <= 1'b1; adv_n <= 1'b0;
      #1 chk(dout, mem[a]);
      @(posedge clock);
      for (int i = 1; i < 4; i++) begin
         @(posedge clock);
         if (i == 3)
            adv_n <= 1'b1;
         #1 chk(dout, mem[lin ? 2'(a + 2'(i)) : (a ^ 2'(i))]);
      end
   endtask
   // ======================================
   // main sequence
   initial begin
      repeat (6) @(posedge clock);
      chk(doe, 32'h00000000);
      arst_n <= 1'b1;
      repeat (2) @(posedge clock);
      wr(16'h0001, 32'h11223344, 1'b0, 4'hF);
      rd(16'h0001);
      for (k = 0; k < 5; k++) begin
         wr(16'h0001, 32'hA0B0C0D0 ^ 32'(k), 1'b1, ~(4'h1 << k));
         rd(16'h0001);
      end
      $display("byte lane writes done");
      @(posedge clock);
      ps_n <= 1'b0; addr <= 16'h0002; oe_n <= 1'b1;
      @(posedge clock);
      ps_n <= 1'b1; gw_n <= 1'b0; cdrv <= 1'b1; cdat <= 32'h5A5AA5A5;
      @(posedge clock);
      gw_n <= 1'b1; cdrv <= 1'b0; oe_n <= 1'b0;
      mem[2] = 32'h5A5AA5A5;
      #1 chk(doe, 32'h00000000);
      rd(16'h0002);
      $display("write after processor strobe done");
      wr(16'h0000, 32'h0F0F3C3C, 1'b0, 4'hF);
      wr(16'h0003, 32'h96692DD2, 1'b1, 4'h0);
      bst(2'h3, 1'b1);
      $display("linear burst done");
      @(posedge clock);
      oe_n <= 1'b1;
      #1 chk(doe, 32'h00000000);
      @(posedge clock);
      oe_n <= 1'b0;
      #1 chk(doe, 32'hFFFFFFFF);
      @(posedge clock);
      ps_n <= 1'b0; ce1_n <= 1'b1;
      @(posedge clock);
      ps_n <= 1'b1; ce1_n <= 1'b0;
      #1 chk(doe, 32'hFFFFFFFF);
      @(posedge clock);
      cs_n <= 1'b0; ce2 <= 1'b0;
      @(posedge clock);
      cs_n <= 1'b1; ce2 <= 1'b1; ce1_n <= 1'b1;
      #1 chk(doe, 32'h00000000);
      $display("output enable and select done");
      @(posedge clock);
      zz <= 1'b1;
      repeat (2) @(posedge clock);
      #1 chk(32'(aslp), 32'h00000001);
      @(posedge clock);
      zz <= 1'b0;
      #1 chk(32'(aslp), 32'h00000000);
      repeat (2) @(posedge clock);
      ce1_n <= 1'b0;
      rd(16'h0002);
      $display("sleep done");
      @(posedge clock);
      arst_n <= 1'b0; strap <= 1'b1;
      repeat (2) @(posedge clock);
      chk(doe, 32'h00000000);
      arst_n <= 1'b1;
      repeat (2) @(posedge clock);
      bst(2'h3, 1'b0);
      $display("interleaved burst done");
      finish_test();
   end
endmodule
